/* File: hw/fragment_assembly_enable_pkg.sv */
// Purpose: Shared types and constants for the fragment reassembler
// Assumes: APB byte address is four times the register index
// Notes:   Object registers sit at index obj*16 + sub-offset
package fragment_assembly_enable_pkg;
   localparam int         NOBJ        = 32;
   localparam logic [9:0] GLOBAL_MESSAGE_CONTROL_IDX    = 10'h27E;
   localparam logic [9:0] SEG_IDX     = 10'h291;
   localparam logic [3:0] SUB_CTL     = 4'h0;
   localparam logic [3:0] SUB_PTR     = 4'h8;
   localparam logic [3:0] SUB_BLR     = 4'hA;
   localparam logic [3:0] SUB_BSZ     = 4'hC;
   localparam logic [3:0] SUB_FCR     = 4'hE;
   localparam logic [7:0] SEG_RST     = 8'hFF;
   localparam logic [7:0] GLOBAL_MESSAGE_CONTROL_RST    = 8'h00;
   localparam logic [7:0] BYTE_CLR    = 8'h00;
   localparam logic [7:0] RESTART_OFF = 8'h01;
   localparam logic [8:0] MIN_SIZE    = 9'h002;
   localparam logic [8:0] FULL_MARGIN = 9'h009;
   localparam logic [7:0] TOG_MASK    = 8'h10;
   localparam logic [1:0] FT_FIRST    = 2'h0;
   localparam logic [1:0] FT_END      = 2'h2;

   typedef enum logic [1:0] {
      P_CAN   = 2'h0,
      P_DNET  = 2'h1,
      P_COPEN = 2'h2,
      P_OSEK  = 2'h3
   } proto_t;

   typedef enum logic [8:0] {
      S_INIT = 9'h001,
      S_IDLE = 9'h002,
      S_ARD  = 9'h004,
      S_AACK = 9'h008,
      S_RD   = 9'h010,
      S_HDR  = 9'h020,
      S_DATA = 9'h040,
      S_CNT  = 9'h080,
      S_UPD  = 9'h100
   } state_t;

   typedef struct packed {
      logic [3:0] rsv;
      logic       auto_ack;
      logic       pre_arb;
      proto_t     proto;
   } global_message_control_t;

   typedef struct packed {
      logic fragment_assembly_enable;
      logic object_enable;
      logic tx;
      logic rtr;
   } ctl_t;

   typedef struct packed {
      ctl_t       ctl;
      logic [2:0] bsz;
      logic [15:0] blr;
      logic [7:0] fcr;
      logic [7:0] ptr;
      logic [7:0] cnt;
   } entry_t;

   localparam int ENTW = $bits(entry_t);

   typedef struct packed {
      logic [4:0]  obj;
      logic        ide;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;
   } frame_t;

   typedef struct packed {
      logic warn;
      logic full;
      logic err;
      logic done;
   } evt_t;

   typedef struct packed {
      state_t      st;
      global_message_control_t       global_message_control;
      logic [7:0]  seg;
      entry_t      ent;
      frame_t      fr;
      logic [3:0]  idx;
      logic [3:0]  last;
      evt_t        flags;
      logic        endm;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        rx_ready;
      logic        mreq;
      logic [23:0] maddr;
      logic [7:0]  mdata;
      logic        evt_valid;
      evt_t        evt;
      logic [4:0]  evt_obj;
      logic        ack_valid;
      logic [4:0]  ack_obj;
      logic        ack_tog;
   } regs_t;
endpackage : fragment_assembly_enable_pkg

/* File: hw/obj_table.sv */
// Purpose: Per-object context memory with registered read data
// Assumes: One access per cycle, read returns old data on write
// Notes:   Contents are cleared by the owner after reset
`timescale 1ns/1ps
`default_nettype none
module obj_table #(
   parameter int WIDTH = 47,
   parameter int DEPTH = 32,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Access port
   input  wire logic             we,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wdata,
   output logic      [WIDTH-1:0] rdata_q
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (reset) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[addr];
      end
   end
endmodule : obj_table
`default_nettype wire

/* File: hw/fragment_assembly_enable_reassembler.sv */
// Purpose: Fragmented message reassembly into per-object memory buffers
// Assumes: APB register access, byte-wide memory writes with grant
// Notes:   Fragment byte formats per protocol are fixed in this block
// Overview of operation
// - DMA writes consecutive offsets from base, wrapping to buffer bottom.
// - Warn before the buffer pointer can wrap.
// - Wrap point comes from the object's buffer size code.
// - Thirty-two objects, each with own pointer and byte count.
// - Fragment byte is data byte 1 and never stored.
// - End fragment: store data, write byte count, then signal completion.
// - Byte count of informational bytes goes to buffer offset zero.
// - Decode first, middle, end and sequence number, or CANopen toggle.
// - Error only on sequence not one more, or toggle not toggled.
// - Error resets count and pointer and signals the processor.
// - Plain CAN protocol disables fragmentation checks everywhere.
// - OSEK: no completion flag, event or count write.
// - OSEK: no zero write at buffer base at message start.
// - CANopen first frame handled as intermediate; software points offset 1.
// - CANopen auto-acknowledge uses transmit object n+1 after good frame.
// - Acknowledge carries the incoming toggle in bit 4.
// - Protocol field: 00 CAN, 01 DeviceNet, 10 CANopen, 11 OSEK.
// - Pre-arbitration bit: 0 by identifier, 1 by object number.
// - Auto-acknowledge enable bit; global control resets to zero.
// - Size code selects 2 to 256 bytes, doubling.
// - CAN buffering: full below 9 bytes left, wrap to offset 1.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fragment_assembly_enable_reassembler #(
   parameter int NUM_OBJ = 32
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // Receive pre-buffer
   input  wire logic                    rx_valid,
   input  wire fragment_assembly_enable_pkg::frame_t        rx_frame,
   output logic                         rx_ready,
   // Memory bus
   output logic                         mem_req,
   output logic      [23:0]             mem_addr,
   output logic      [7:0]              mem_wdata,
   input  wire logic                    mem_gnt,
   // Events to processor
   output logic                         evt_valid,
   output fragment_assembly_enable_pkg::evt_t               evt_flags,
   output logic      [4:0]              evt_obj,
   // Auto-acknowledge request
   output logic                         ack_valid,
   output logic      [4:0]              ack_obj,
   output logic                         ack_toggle,
   // Global settings
   output fragment_assembly_enable_pkg::proto_t             protocol,
   output logic                         pre_arb_by_number,
   output logic                         auto_ack_en
);
   import fragment_assembly_enable_pkg::*;

   regs_t      q;
   regs_t      d;
   entry_t     rd_ent;
   entry_t     wr_ent;
   logic       we;
   logic [4:0] tab_addr;
   logic [9:0] idx_p;
   logic [8:0] size;
   logic [7:0] mask;
   logic [7:0] off_n;
   logic       wrap;
   logic       can_buf;
   logic [7:0] fb;
   logic       chk_bad;
   logic       chk_end;
   logic       chk_first;
   logic [7:0] chk_fcr;
   evt_t       flags_out;

   function automatic logic [7:0] mask_of(input logic [2:0] bsz);
      logic [8:0] s;
      s = MIN_SIZE << bsz;
      mask_of = 8'(s - 9'h001);
   endfunction : mask_of

   function automatic logic [23:0] baddr(input logic [7:0] seg, input entry_t e,
                                         input logic [7:0] off);
      logic [7:0] m;
      m = mask_of(e.bsz);
      baddr = {seg, e.blr[15:8], (e.blr[7:0] & ~m) | (off & m)};
   endfunction : baddr

   obj_table #(
      .WIDTH (ENTW),
      .DEPTH (NUM_OBJ),
      .AW    (5)
   ) u_tab (
      .clk     (clk),
      .reset   (reset),
      .we      (we),
      .addr    (tab_addr),
      .wdata   (wr_ent),
      .rdata_q (rd_ent)
   );

   assign idx_p   = paddr[11:2];
   assign size    = MIN_SIZE << q.ent.bsz;
   assign mask    = mask_of(q.ent.bsz);
   assign can_buf = q.global_message_control.proto == P_CAN;

   // Next offset, wrapping at the buffer top
   always_comb begin
      off_n = 8'(q.ent.ptr + 8'h01) & mask;
      wrap  = off_n == BYTE_CLR;
      if (wrap && can_buf) begin
         off_n = RESTART_OFF;
      end
   end

   // Fragment byte decode and sequence check
   always_comb begin
      fb        = q.fr.data[7:0];
      chk_first = fb[7:6] == FT_FIRST;
      chk_end   = 1'b0;
      chk_bad   = 1'b0;
      chk_fcr   = rd_ent.fcr;
      case (q.global_message_control.proto)
         P_DNET: begin
            chk_end = fb[7:6] == FT_END;
            chk_bad = !chk_first && (fb[5:0] != rd_ent.fcr[5:0]);
            chk_fcr = {2'h0, 6'(fb[5:0] + 6'h01)};
         end
         P_COPEN: begin
            chk_first = 1'b0;
            chk_end   = fb[0];
            chk_bad   = fb[4] != rd_ent.fcr[4];
            chk_fcr   = rd_ent.fcr ^ TOG_MASK;
         end
         P_OSEK: begin
            chk_first = 1'b0;
            chk_bad   = fb[3:0] != rd_ent.fcr[3:0];
            chk_fcr   = {4'h0, 4'(fb[3:0] + 4'h1)};
         end
         default: begin
            chk_first = 1'b0;
         end
      endcase
   end

   // Events raised at the end of a frame
   always_comb begin
      flags_out = q.flags;
      if (!q.flags.err && q.ent.ctl.fragment_assembly_enable
          && (size - {1'b0, q.ent.ptr}) < FULL_MARGIN) begin
         if (can_buf) begin
            flags_out.full = 1'b1;
         end else begin
            flags_out.warn = 1'b1;
         end
      end
   end

   always_comb begin
      d           = q;
      we          = 1'b0;
      tab_addr    = q.fr.obj;
      wr_ent      = q.ent;
      d.pready    = 1'b0;
      d.rx_ready  = 1'b0;
      d.evt_valid = 1'b0;
      d.ack_valid = 1'b0;
      case (q.st)
         S_INIT: begin
            we       = 1'b1;
            wr_ent   = '0;
            d.fr.obj = 5'(q.fr.obj + 5'h01);
            if (q.fr.obj == 5'(NUM_OBJ - 1)) begin
               d.st = S_IDLE;
            end
         end
         S_IDLE: begin
            if (psel && penable) begin
               tab_addr = idx_p[8:4];
               d.fr.obj = idx_p[8:4];
               d.st     = S_ARD;
            end else if (rx_valid) begin
               tab_addr   = rx_frame.obj;
               d.fr       = rx_frame;
               d.rx_ready = 1'b1;
               d.st       = S_RD;
            end
         end
         S_ARD: begin
            d.ent     = rd_ent;
            d.pready  = 1'b1;
            d.pslverr = 1'b0;
            d.prdata  = '0;
            if (idx_p == GLOBAL_MESSAGE_CONTROL_IDX) begin
               d.prdata = {24'h0, q.global_message_control};
            end else if (idx_p == SEG_IDX) begin
               d.prdata = {24'h0, q.seg};
            end else if (!idx_p[9]) begin
               case (idx_p[3:0])
                  SUB_CTL: d.prdata = {28'h0, rd_ent.ctl};
                  SUB_PTR: d.prdata = {16'h0, rd_ent.cnt, rd_ent.ptr};
                  SUB_BLR: d.prdata = {16'h0, rd_ent.blr};
                  SUB_BSZ: d.prdata = {29'h0, rd_ent.bsz};
                  SUB_FCR: d.prdata = {24'h0, rd_ent.fcr};
                  default: d.pslverr = 1'b1;
               endcase
            end else begin
               d.pslverr = 1'b1;
            end
            d.st = S_AACK;
         end
         S_AACK: begin
            if (pwrite && !q.pslverr) begin
               if (idx_p == GLOBAL_MESSAGE_CONTROL_IDX) begin
                  d.global_message_control = global_message_control_t'({4'h0, pwdata[3:0]});
               end else if (idx_p == SEG_IDX) begin
                  d.seg = pwdata[7:0];
               end else begin
                  we = 1'b1;
                  case (idx_p[3:0])
                     SUB_CTL: wr_ent.ctl = ctl_t'(pwdata[3:0]);
                     SUB_PTR: wr_ent.ptr = pwdata[7:0];
                     SUB_BLR: wr_ent.blr = pwdata[15:0];
                     SUB_BSZ: wr_ent.bsz = pwdata[2:0];
                     SUB_FCR: wr_ent.fcr = pwdata[7:0];
                     default: we = 1'b0;
                  endcase
               end
            end
            d.st = S_IDLE;
         end
         S_RD: begin
            d.ent   = rd_ent;
            d.flags = '0;
            d.endm  = 1'b0;
            d.idx   = 4'h0;
            d.last  = (q.fr.dlc > 4'h8) ? 4'h8 : q.fr.dlc;
            if (!rd_ent.ctl.object_enable || rd_ent.ctl.tx) begin
               d.st = S_IDLE;
            end else if (rd_ent.ctl.fragment_assembly_enable && !can_buf) begin
               if (chk_bad) begin
                  d.flags.err = 1'b1;
                  d.ent.cnt   = BYTE_CLR;
                  d.ent.ptr   = RESTART_OFF;
                  d.st        = S_UPD;
               end else begin
                  d.idx     = 4'h1;
                  d.ent.fcr = chk_fcr;
                  d.endm    = chk_end;
                  d.st      = S_DATA;
                  if (chk_first) begin
                     d.ent.ptr = BYTE_CLR;
                     d.ent.cnt = BYTE_CLR;
                     d.mreq    = 1'b1;
                     d.maddr   = baddr(q.seg, rd_ent, BYTE_CLR);
                     d.mdata   = BYTE_CLR;
                     d.st      = S_HDR;
                  end
               end
            end else if (rd_ent.ctl.fragment_assembly_enable) begin
               d.mreq  = 1'b1;
               d.maddr = baddr(q.seg, rd_ent, rd_ent.ptr);
               d.mdata = {q.fr.ide, q.fr.rtr, 2'h3, q.fr.dlc};
               d.st    = S_HDR;
            end else begin
               d.ent.ptr = RESTART_OFF;
               d.endm    = 1'b1;
               d.st      = S_DATA;
            end
         end
         S_HDR: begin
            if (mem_gnt) begin
               d.mreq    = 1'b0;
               d.ent.ptr = off_n;
               d.st      = S_DATA;
            end
         end
         S_DATA: begin
            if (q.mreq) begin
               if (mem_gnt) begin
                  d.mreq    = 1'b0;
                  d.idx     = 4'(q.idx + 4'h1);
                  d.ent.ptr = off_n;
                  d.ent.cnt = 8'(q.ent.cnt + 8'h01);
                  if (wrap) begin
                     d.flags.full = 1'b1;
                  end
               end
            end else if (q.idx < q.last) begin
               d.mreq  = 1'b1;
               d.maddr = baddr(q.seg, q.ent, q.ent.ptr);
               d.mdata = q.fr.data[{q.idx[2:0], 3'h0} +: 8];
            end else if (q.endm) begin
               d.mreq  = 1'b1;
               d.maddr = baddr(q.seg, q.ent, BYTE_CLR);
               d.mdata = q.ent.ctl.fragment_assembly_enable ? q.ent.cnt
                         : {q.fr.ide, q.fr.rtr, 2'h3, q.fr.dlc};
               d.st    = S_CNT;
            end else begin
               d.st = S_UPD;
            end
         end
         S_CNT: begin
            if (mem_gnt) begin
               d.mreq       = 1'b0;
               d.flags.done = 1'b1;
               d.ent.cnt    = BYTE_CLR;
               d.ent.ptr    = RESTART_OFF;
               d.st         = S_UPD;
            end
         end
         S_UPD: begin
            we          = 1'b1;
            d.evt_valid = |flags_out;
            d.evt       = flags_out;
            d.evt_obj   = q.fr.obj;
            if (!q.flags.err && q.global_message_control.auto_ack && q.global_message_control.proto == P_COPEN
                && q.ent.ctl.fragment_assembly_enable && q.fr.obj != 5'h1F) begin
               d.ack_valid = 1'b1;
               d.ack_obj   = 5'(q.fr.obj + 5'h01);
               d.ack_tog   = q.fr.data[4];
            end
            d.st = S_IDLE;
         end
         default: d.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q      <= '0;
         q.st   <= S_INIT;
         q.global_message_control <= global_message_control_t'(GLOBAL_MESSAGE_CONTROL_RST);
         q.seg  <= SEG_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata            = q.prdata;
   assign pready            = q.pready;
   assign pslverr           = q.pslverr;
   assign rx_ready          = q.rx_ready;
   assign mem_req           = q.mreq;
   assign mem_addr          = q.maddr;
   assign mem_wdata         = q.mdata;
   assign evt_valid         = q.evt_valid;
   assign evt_flags         = q.evt;
   assign evt_obj           = q.evt_obj;
   assign ack_valid         = q.ack_valid;
   assign ack_obj           = q.ack_obj;
   assign ack_toggle        = q.ack_tog;
   assign protocol          = q.global_message_control.proto;
   assign pre_arb_by_number = q.global_message_control.pre_arb;
   assign auto_ack_en       = q.global_message_control.auto_ack;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence cnt_taken;
      q.st == S_CNT && q.mreq && mem_gnt;
   endsequence
   sequence done_evt;
      ##1 q.st == S_UPD ##1 (q.evt_valid && q.evt.done);
   endsequence

   done_after_cnt_a: assert property (cnt_taken |-> done_evt)
      else $error("completion event did not follow count write");
   cnt_value_a: assert property ((q.st == S_CNT && q.mreq && q.ent.ctl.fragment_assembly_enable)
      |-> (q.mdata == q.ent.cnt && q.maddr == baddr(q.seg, q.ent, BYTE_CLR)))
      else $error("byte count write wrong value or address");
   buf_bound_a: assert property (q.mreq
      |-> (q.maddr[7:0] & ~mask) == (q.ent.blr[7:0] & ~mask))
      else $error("buffer write outside the buffer");
   fragment_assembly_enable_skip_a: assert property ((q.st == S_DATA && q.mreq && !can_buf
      && q.ent.ctl.fragment_assembly_enable) |-> q.idx != 4'h0)
      else $error("fragment byte stored");
   can_no_err_a: assert property ((q.st == S_RD && can_buf) |=> !q.flags.err)
      else $error("fragment error raised in plain CAN mode");
   osek_no_cnt_a: assert property ((q.st == S_CNT && q.global_message_control.proto == P_OSEK)
      |-> !q.ent.ctl.fragment_assembly_enable)
      else $error("completion count write in OSEK fragment mode");
   no_start_wr_a: assert property ((q.st == S_HDR)
      |-> !(q.global_message_control.proto inside {P_OSEK, P_COPEN}))
      else $error("start write issued in OSEK or CANopen");
   err_reset_a: assert property ((q.st == S_UPD && q.flags.err)
      |-> (q.ent.cnt == BYTE_CLR && q.ent.ptr == RESTART_OFF) ##1 (q.evt_valid && q.evt.err))
      else $error("fragment error did not reset and signal");
   ack_form_a: assert property (q.ack_valid |-> (q.global_message_control.proto == P_COPEN
      && q.ack_obj == 5'(q.fr.obj + 5'h01) && q.ack_tog == q.fr.data[4]))
      else $error("acknowledge object or toggle wrong");
   tog_adv_a: assert property ((q.st == S_UPD && !q.flags.err && q.global_message_control.proto == P_COPEN
      && q.ent.ctl.fragment_assembly_enable) |-> q.ent.fcr[4] != q.fr.data[4])
      else $error("toggle expectation not advanced");
endmodule : fragment_assembly_enable_reassembler
`default_nettype wire

/* File: verif/mem_model.sv */
// Purpose: Memory bus partner that grants byte writes
// Assumes: One write request outstanding at a time
// Notes:   Slow mode waits two cycles before each grant
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   // Clock
   input  wire logic        clk,
   // Memory bus
   input  wire logic        mem_req,
   input  wire logic [23:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic             mem_gnt,
   // Control
   input  wire logic        slow
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_q;
   initial begin
      mem_gnt = 1'b0;
      wait_q = 2'h0;
   end
   always @(posedge clk) begin
      mem_gnt <= 1'b0;
      if (mem_req && mem_gnt) begin
         mem[mem_addr[15:0]] <= mem_wdata;
      end
      if (mem_req && !mem_gnt) begin
         if (wait_q == (slow ? 2'h2 : 2'h0)) begin
            mem_gnt <= 1'b1;
            wait_q <= 2'h0;
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end
endmodule : mem_model
`default_nettype wire

/* File: verif/ctl_fragment_reassembler_tb.sv */
// Purpose: Self-checking bench for the fragment reassembler
// Assumes: APB index times four is the byte address
// Notes:   Frame payload byte k from 1 to 7 carries base value plus k
`timescale 1ns/1ps
`default_nettype none
module ctl_fragment_reassembler_tb;
   import fragment_assembly_enable_pkg::*;
   logic        clk, reset, psel, penable, pwrite, rx_valid, slow, pready, pslverr;
   logic        rx_ready, mem_req, mem_gnt, evt_valid, ack_valid, ack_toggle, last_tog;
   logic        pre_arb_by_number, auto_ack_en, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [23:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic [4:0]  evt_obj, ack_obj, last_obj, last_ack;
   frame_t      rx_frame;
   evt_t        evt_flags, last_evt;
   proto_t      protocol;
   int          fail_count, compares, cycles, evt_n, ack_n, a0;
   fragment_assembly_enable_reassembler dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt),
      .evt_valid(evt_valid), .evt_flags(evt_flags), .evt_obj(evt_obj), .ack_valid(ack_valid),
      .ack_obj(ack_obj), .ack_toggle(ack_toggle), .protocol(protocol),
      .pre_arb_by_number(pre_arb_by_number), .auto_ack_en(auto_ack_en));
   mem_model mem_u (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .slow(slow));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (evt_valid === 1'b1) begin
         last_evt = evt_flags;
         last_obj = evt_obj;
         evt_n++;
      end
      if (ack_valid === 1'b1) begin
         last_ack = ack_obj;
         last_tog = ack_toggle;
         ack_n++;
      end
      if (cycles == 30000) begin
         fail_count++;
         complete_run();
      end
   end
   task complete_run();
      $display("mismatches %0d comparisons %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [11:0] oa(input int n, input int s);
      return 12'((n * 16 + s) * 4);
   endfunction : oa
   task cfg(input int n, input logic [15:0] base);
      apb(1'b1, oa(n, 0), 32'h0000000C);
      apb(1'b1, oa(n, 10), {16'h0, base});
      apb(1'b1, oa(n, 12), 32'h00000007);
      apb(1'b1, oa(n, 14), 32'h00000000);
      apb(1'b1, oa(n, 8), 32'h00000001);
   endtask : cfg
   task send(input logic [4:0] o, input logic [7:0] b1, input logic [3:0] l, input logic [7:0] p);
      int n, e0;
      logic [63:0] d;
      d[7:0] = b1;
      for (int k = 1; k < 8; k++) d[8*k+:8] = p + 8'(k);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_frame <= '{obj: o, ide: 1'b0, rtr: 1'b0, dlc: l, data: d};
      do begin
         @(posedge clk);
      end while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      e0 = evt_n + ack_n;
      for (n = 0; n < 60 && evt_n + ack_n == e0; n++) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask : send
   task t_global_message_control();
      apb(1'b0, {GLOBAL_MESSAGE_CONTROL_IDX, 2'b00}, 32'h0);
      chk("global_message_control reset", 32'h0, r);
      apb(1'b0, {SEG_IDX, 2'b00}, 32'h0);
      chk("segment reset", {24'h0, SEG_RST}, r);
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, {GLOBAL_MESSAGE_CONTROL_IDX, 2'b00}, 32'(p | (p << 2)));
         apb(1'b0, {GLOBAL_MESSAGE_CONTROL_IDX, 2'b00}, 32'h0);
         chk("global_message_control", 32'(p | (p << 2)), r);
         chk("global_message_control ports", 32'(p | (p << 2)), {28'h0, auto_ack_en, pre_arb_by_number, protocol});
      end
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped", 32'h1, {31'h0, last_err});
   endtask : t_global_message_control
   task t_dnet();
      slow <= 1'b1;
      apb(1'b1, {GLOBAL_MESSAGE_CONTROL_IDX, 2'b00}, 32'h1);
      cfg(2, 16'h0100);
      send(5'd2, 8'h00, 4'd8, 8'h10);
      send(5'd2, 8'h81, 4'd4, 8'h20);
      chk("done evt", 32'h00000022, {23'h0, last_evt, last_obj});
      chk("byte count", 32'h0A, {24'h0, mem_u.mem[16'h0100]});
      for (int j = 1; j < 8; j++) chk("data", 32'(8'h10 + j), {24'h0, mem_u.mem[16'h0100 + j]});
      for (int j = 1; j < 4; j++) chk("data", 32'(8'h20 + j), {24'h0, mem_u.mem[16'h0107 + j]});
      slow <= 1'b0;
   endtask : t_dnet
   task t_err();
      cfg(3, 16'h0300);
      send(5'd3, 8'h00, 4'd8, 8'h30);
      send(5'd3, 8'h45, 4'd8, 8'h40);
      chk("err evt", 32'h00000043, {23'h0, last_evt, last_obj});
      apb(1'b0, oa(3, 8), 32'h0);
      chk("ptr count", 32'h1, r);
   endtask : t_err
   task t_copen();
      apb(1'b1, {GLOBAL_MESSAGE_CONTROL_IDX, 2'b00}, 32'h0000000A);
      cfg(4, 16'h0400);
      apb(1'b1, oa(5, 0), 32'h0000000A);
      a0 = ack_n;
      send(5'd4, 8'h00, 4'd8, 8'h50);
      chk("ack", 32'h05, {26'h0, last_tog, last_ack});
      apb(1'b0, oa(4, 14), 32'h0);
      chk("next toggle", 32'h10, r);
      send(5'd4, 8'h10, 4'd8, 8'h60);
      chk("ack", 32'h25, {26'h0, last_tog, last_ack});
      chk("ack count", 32'(a0 + 2), 32'(ack_n));
      chk("first data", 32'h51, {24'h0, mem_u.mem[16'h0401]});
   endtask : t_copen
   task t_osek();
      apb(1'b1, {GLOBAL_MESSAGE_CONTROL_IDX, 2'b00}, 32'h3);
      cfg(6, 16'h0600);
      apb(1'b1, oa(6, 12), 32'h00000003);
      send(5'd6, 8'h00, 4'd8, 8'h70);
      chk("warn evt", 32'h00000106, {23'h0, last_evt, last_obj});
      send(5'd6, 8'h01, 4'd8, 8'h80);
      send(5'd6, 8'h02, 4'd8, 8'h90);
      chk("full evt", 32'h00000086, {23'h0, last_evt, last_obj});
      chk("top data", 32'h91, {24'h0, mem_u.mem[16'h060F]});
      chk("wrap data", 32'h92, {24'h0, mem_u.mem[16'h0600]});
   endtask : t_osek
   task t_can();
      apb(1'b1, {GLOBAL_MESSAGE_CONTROL_IDX, 2'b00}, 32'h0);
      cfg(7, 16'h0700);
      send(5'd7, 8'h45, 4'd2, 8'hA0);
      chk("can info", 32'h32, {24'h0, mem_u.mem[16'h0701]});
      chk("can byte 1", 32'h45, {24'h0, mem_u.mem[16'h0702]});
      chk("can byte 2", 32'hA1, {24'h0, mem_u.mem[16'h0703]});
   endtask : t_can
   initial begin
      {clk, psel, penable, pwrite, rx_valid, slow} = '0;
      {paddr, pwdata, rx_frame} = '0;
      {fail_count, compares, cycles, evt_n, ack_n} = '0;
      reset = 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_global_message_control();
      t_dnet();
      t_err();
      t_copen();
      t_osek();
      t_can();
      complete_run();
   end
endmodule : ctl_fragment_reassembler_tb
`default_nettype wire
